// *** logic/tmc_pkg.sv ***
// Shared constants, types and carriers of the 8-bit timer control block
package tmc_pkg;

  // Register offsets in data space
  localparam logic [7:0] TMC_ADDR_FLAGS  = 8'h35;
  localparam logic [7:0] TMC_ADDR_SYNC   = 8'h43;
  localparam logic [7:0] TMC_ADDR_CTRL_A = 8'h44;
  localparam logic [7:0] TMC_ADDR_CTRL_B = 8'h45;
  localparam logic [7:0] TMC_ADDR_COUNT  = 8'h46;
  localparam logic [7:0] TMC_ADDR_CMP_A  = 8'h47;
  localparam logic [7:0] TMC_ADDR_CMP_B  = 8'h48;
  localparam logic [7:0] TMC_ADDR_MASK   = 8'h6E;

  // Values after reset, counter landmarks and the control A write mask
  localparam logic [7:0] TMC_RESET_VALUE  = 8'h00;
  localparam logic [7:0] TMC_MAX_VALUE    = 8'hFF;
  localparam logic [7:0] TMC_BOTTOM_VALUE = 8'h00;
  localparam logic [7:0] TMC_CTRL_A_MASK  = 8'hF3;

  // Field positions
  localparam int unsigned TMC_BIT_FORCE_A    = 7;
  localparam int unsigned TMC_BIT_FORCE_B    = 6;
  localparam int unsigned TMC_BIT_WAVE_HIGH  = 3;
  localparam int unsigned TMC_BIT_SYNC_HOLD  = 7;
  localparam int unsigned TMC_BIT_ASYNC_RST  = 1;
  localparam int unsigned TMC_BIT_SHARED_RST = 0;
  localparam int unsigned TMC_COM_A_LSB      = 6;
  localparam int unsigned TMC_COM_B_LSB      = 4;
  localparam int unsigned TMC_FLAG_OVF       = 0;
  localparam int unsigned TMC_FLAG_CMP_A     = 1;
  localparam int unsigned TMC_FLAG_CMP_B     = 2;

  // Prescaler length: the longest division is 2**10
  localparam int unsigned TMC_PRESC_WIDTH = 10;

  typedef enum logic [2:0] {
    CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } tmc_clksel_t;

  typedef enum logic [2:0] {
    WM_NORMAL, WM_PC_MAX, WM_CTC, WM_FAST_MAX, WM_RSV4, WM_PC_CMPA, WM_RSV6, WM_FAST_CMPA
  } tmc_wmode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tmc_iobus_t;

endpackage

// *** logic/tmc_prescaler.sv ***
// Shared clock prescaler with tap selection
module tmc_prescaler
  import tmc_pkg::*;
#(
  parameter int unsigned WIDTH = TMC_PRESC_WIDTH
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_clock_enable,
  input  wire logic        i_clear,
  input  wire tmc_clksel_t i_select,
  output logic             o_tick
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } tmc_presc_state_t;

  tmc_presc_state_t st;
  tmc_presc_state_t nxt;

  always_comb begin
    nxt = st;
    nxt.count = i_clear ? '0 : st.count + 1'b1;
    o_tick = 1'b0;
    unique case (i_select)
      CS_DIV1:    o_tick = 1'b1;
      CS_DIV8:    o_tick = &st.count[2:0];
      CS_DIV64:   o_tick = &st.count[5:0];
      CS_DIV256:  o_tick = &st.count[7:0];
      CS_DIV1024: o_tick = &st.count[9:0];
      CS_STOP, CS_EXT_FALL, CS_EXT_RISE: o_tick = 1'b0;
    endcase
    // Held reset keeps the prescaled timers halted
    if (i_clear && i_select != CS_DIV1) begin
      o_tick = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_clock_enable) begin
      st <= nxt;
    end
  end

endmodule

// *** logic/tmc_pin_edge.sv ***
// Edge detector for the external count pin
module tmc_pin_edge
  import tmc_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_clock_enable,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);

  typedef struct packed {
    logic prev;
  } tmc_edge_state_t;

  tmc_edge_state_t st;
  tmc_edge_state_t nxt;

  always_comb begin
    nxt.prev = i_pin;
    o_rise   = i_pin & ~st.prev;
    o_fall   = ~i_pin & st.prev;
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_clock_enable) begin
      st <= nxt;
    end
  end

endmodule

// *** logic/tmc_timer_core.sv ***
// Timer 0 mode, clock select, force compare, interrupt mask and prescaler control
////////////////////////////////////////////////////////////////////////////////
module tmc_timer_core
  import tmc_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_clock_enable,
  input  wire tmc_iobus_t i_bus,
  input  wire logic       i_global_irq_enable,
  input  wire logic [2:0] i_vector_ack,
  input  wire logic       i_external_count_pin,
  input  wire logic       i_async_mode,
  input  wire logic       i_async_reset_done,
  output logic [7:0]      o_rdata,
  output logic            o_wave_out_a,
  output logic            o_wave_out_b,
  output logic [2:0]      o_irq_request,
  output logic            o_shared_prescaler_reset,
  output logic            o_async_prescaler_reset
);

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic        wave_mode_high_bit;
    tmc_clksel_t clock_select_field;
    logic [7:0]  count;
    logic [7:0]  cmp_a_buf;
    logic [7:0]  cmp_b_buf;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [2:0]  flags;
    logic [2:0]  mask;
    logic        sync_hold_mode;
    logic        async_prescaler_reset;
    logic        shared_prescaler_reset;
    logic        count_down;
    logic        suppress;
    logic        wave_a;
    logic        wave_b;
    logic [2:0]  irq;
    logic [7:0]  rdata;
  } tmc_core_state_t;

  tmc_core_state_t st;
  tmc_core_state_t nxt;

  logic       presc_tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       tick;
  logic       hit_a;
  logic       hit_b;
  logic       ovf;
  logic       load;
  logic       is_pwm;
  logic       force_a;
  logic       force_b;
  logic [7:0] top;
  tmc_wmode_t mode;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic bus_write(input tmc_iobus_t b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // Next wave level from output mode, match, bottom and count direction
  function automatic logic wave_next(input logic [1:0] com, input logic cur,
                                     input logic match, input logic bottom,
                                     input logic up, input tmc_wmode_t m,
                                     input logic may_toggle);
    logic res;
    res = cur;
    unique case (m)
      WM_FAST_MAX, WM_FAST_CMPA: begin
        if (com == 2'b01 && may_toggle && match) begin
          res = ~cur;
        end else if (com[1]) begin
          if (match) begin
            res = com[0];
          end
          if (bottom) begin
            res = ~com[0];
          end
        end
      end
      WM_PC_MAX, WM_PC_CMPA: begin
        if (com == 2'b01 && may_toggle && match) begin
          res = ~cur;
        end else if (com[1] && match) begin
          res = up ? com[0] : ~com[0];
        end
      end
      default: begin
        if (match) begin
          unique case (com)
            2'b00: res = cur;
            2'b01: res = ~cur;
            2'b10: res = 1'b0;
            2'b11: res = 1'b1;
          endcase
        end
      end
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  tmc_prescaler #(
    .WIDTH (TMC_PRESC_WIDTH)
  ) u_prescaler (
    .i_clock        (i_clock),
    .i_resetn       (i_resetn),
    .i_clock_enable (i_clock_enable),
    .i_clear        (st.shared_prescaler_reset),
    .i_select       (st.clock_select_field),
    .o_tick         (presc_tick)
  );

  // Pin is sampled whatever its port direction
  tmc_pin_edge u_pin_edge (
    .i_clock        (i_clock),
    .i_resetn       (i_resetn),
    .i_clock_enable (i_clock_enable),
    .i_pin          (i_external_count_pin),
    .o_rise         (pin_rise),
    .o_fall         (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt = st;
    mode = tmc_wmode_t'({st.wave_mode_high_bit, st.ctrl_a[1:0]});
    is_pwm = mode inside {WM_PC_MAX, WM_FAST_MAX, WM_PC_CMPA, WM_FAST_CMPA};
    top = (mode inside {WM_CTC, WM_PC_CMPA, WM_FAST_CMPA}) ? st.cmp_a : TMC_MAX_VALUE;
    unique case (st.clock_select_field)
      CS_EXT_FALL: tick = pin_fall;
      CS_EXT_RISE: tick = pin_rise;
      default:     tick = presc_tick;
    endcase
    hit_a = tick && !st.suppress && (st.count == st.cmp_a);
    hit_b = tick && !st.suppress && (st.count == st.cmp_b);
    ovf = 1'b0;
    load = 1'b0;
    if (tick) begin
      nxt.suppress = 1'b0;
      unique case (mode)
        WM_NORMAL, WM_CTC: begin
          nxt.count = (st.count == top) ? TMC_BOTTOM_VALUE : st.count + 8'h01;
          ovf = (st.count == TMC_MAX_VALUE);
        end
        WM_FAST_MAX, WM_FAST_CMPA: begin
          nxt.count = (st.count == top) ? TMC_BOTTOM_VALUE : st.count + 8'h01;
          load = (st.count == top);
          ovf = (st.count == top);
        end
        WM_PC_MAX, WM_PC_CMPA: begin
          if (!st.count_down) begin
            load = (st.count == top);
            nxt.count_down = (st.count == top);
            nxt.count = (st.count == top) ? st.count - 8'h01 : st.count + 8'h01;
          end else begin
            ovf = (st.count == TMC_BOTTOM_VALUE);
            nxt.count_down = (st.count != TMC_BOTTOM_VALUE);
            nxt.count = (st.count == TMC_BOTTOM_VALUE) ? st.count + 8'h01 : st.count - 8'h01;
          end
        end
        WM_RSV4, WM_RSV6: nxt.count = st.count;
      endcase
    end
    if (!is_pwm) begin
      nxt.count_down = 1'b0;
    end
    // Non-PWM modes take compare values at once
    if (!is_pwm || load) begin
      nxt.cmp_a = st.cmp_a_buf;
      nxt.cmp_b = st.cmp_b_buf;
    end

    // Forced match touches only the wave outputs
    force_a = !is_pwm && bus_write(i_bus, TMC_ADDR_CTRL_B) && i_bus.wdata[TMC_BIT_FORCE_A];
    force_b = !is_pwm && bus_write(i_bus, TMC_ADDR_CTRL_B) && i_bus.wdata[TMC_BIT_FORCE_B];
    nxt.wave_a = wave_next(st.ctrl_a[TMC_COM_A_LSB +: 2], st.wave_a, hit_a || force_a,
                           load, !st.count_down, mode, st.wave_mode_high_bit);
    nxt.wave_b = wave_next(st.ctrl_a[TMC_COM_B_LSB +: 2], st.wave_b, hit_b || force_b,
                           load, !st.count_down, mode, 1'b0);

    // Set wins over clear; force strobes never reach the flags
    nxt.flags = (st.flags & ~(i_vector_ack |
                 ({3{bus_write(i_bus, TMC_ADDR_FLAGS)}} & i_bus.wdata[2:0])))
                | {hit_b, hit_a, ovf};
    nxt.irq = st.flags & st.mask & {3{i_global_irq_enable}};

    // Prescaler reset bits self-clear unless held; the async bit also stays set in async mode until i_async_reset_done
    if (!st.sync_hold_mode) begin
      nxt.shared_prescaler_reset = 1'b0;
      if (!(i_async_mode && !i_async_reset_done)) begin
        nxt.async_prescaler_reset = 1'b0;
      end
    end

    if (bus_write(i_bus, TMC_ADDR_SYNC)) begin
      nxt.sync_hold_mode = i_bus.wdata[TMC_BIT_SYNC_HOLD];
      nxt.shared_prescaler_reset = i_bus.wdata[TMC_BIT_SHARED_RST];
      nxt.async_prescaler_reset = i_bus.wdata[TMC_BIT_ASYNC_RST];
    end
    if (bus_write(i_bus, TMC_ADDR_CTRL_A)) begin
      nxt.ctrl_a = i_bus.wdata & TMC_CTRL_A_MASK;
    end
    if (bus_write(i_bus, TMC_ADDR_CTRL_B)) begin
      nxt.wave_mode_high_bit = i_bus.wdata[TMC_BIT_WAVE_HIGH];
      nxt.clock_select_field = tmc_clksel_t'(i_bus.wdata[2:0]);
    end
    if (bus_write(i_bus, TMC_ADDR_COUNT)) begin
      nxt.count = i_bus.wdata;
      nxt.suppress = 1'b1;
    end
    if (bus_write(i_bus, TMC_ADDR_CMP_A)) begin
      nxt.cmp_a_buf = i_bus.wdata;
    end
    if (bus_write(i_bus, TMC_ADDR_CMP_B)) begin
      nxt.cmp_b_buf = i_bus.wdata;
    end
    if (bus_write(i_bus, TMC_ADDR_MASK)) begin
      nxt.mask = i_bus.wdata[2:0];
    end

    if (i_bus.rd) begin
      unique case (i_bus.addr)
        TMC_ADDR_CTRL_A: nxt.rdata = st.ctrl_a;
        TMC_ADDR_CTRL_B: nxt.rdata = {4'h0, st.wave_mode_high_bit, st.clock_select_field};
        TMC_ADDR_COUNT:  nxt.rdata = st.count;
        TMC_ADDR_CMP_A:  nxt.rdata = st.cmp_a_buf;
        TMC_ADDR_CMP_B:  nxt.rdata = st.cmp_b_buf;
        TMC_ADDR_FLAGS:  nxt.rdata = {5'h00, st.flags};
        TMC_ADDR_MASK:   nxt.rdata = {5'h00, st.mask};
        TMC_ADDR_SYNC:   nxt.rdata = {st.sync_hold_mode, 5'h00, st.async_prescaler_reset,
                                      st.shared_prescaler_reset};
        default:         nxt.rdata = TMC_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_clock_enable) begin
      st <= nxt;
    end
  end

  assign o_rdata                  = st.rdata;
  assign o_wave_out_a             = st.wave_a;
  assign o_wave_out_b             = st.wave_b;
  assign o_irq_request            = st.irq;
  assign o_shared_prescaler_reset = st.shared_prescaler_reset;
  assign o_async_prescaler_reset  = st.async_prescaler_reset;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  sequence s_count_write;
    i_clock_enable && bus_write(i_bus, TMC_ADDR_COUNT);
  endsequence

  sequence s_blocked_tick;
    i_clock_enable && st.suppress && tick && !bus_write(i_bus, TMC_ADDR_FLAGS);
  endsequence

  a_force_no_flag: assert property (
    $rose(st.flags[TMC_FLAG_CMP_A]) |-> $past(hit_a))
    else $error("Compare A flag rose without a compare match");

  a_force_read_zero: assert property (
    (i_clock_enable && i_bus.rd && i_bus.addr == TMC_ADDR_CTRL_B) |=> (o_rdata[7:6] == 2'b00))
    else $error("Force compare bits did not read as zero");

  a_stop_holds: assert property (
    (i_clock_enable && st.clock_select_field == CS_STOP && !i_bus.wr)
      |=> (st.count == $past(st.count)))
    else $error("Counter moved with no clock source");

  a_count_write: assert property (
    s_count_write |=> (st.count == $past(i_bus.wdata)) && st.suppress)
    else $error("Counter write did not land");

  a_blocked_match: assert property (
    s_blocked_tick |=> !$rose(st.flags[TMC_FLAG_CMP_A]) && !$rose(st.flags[TMC_FLAG_CMP_B]))
    else $error("Compare match not blocked after counter write");

  a_irq_gating: assert property (
    i_clock_enable |=> (o_irq_request == $past(st.flags & st.mask & {3{i_global_irq_enable}})))
    else $error("Interrupt request does not follow flag, mask and global bit");

  a_shared_clear: assert property (
    (i_clock_enable && st.shared_prescaler_reset && !st.sync_hold_mode
     && !bus_write(i_bus, TMC_ADDR_SYNC)) |=> !o_shared_prescaler_reset)
    else $error("Shared prescaler reset did not self-clear");

  a_sync_keep: assert property (
    (i_clock_enable && st.sync_hold_mode && !bus_write(i_bus, TMC_ADDR_SYNC))
      |=> $stable({st.shared_prescaler_reset, st.async_prescaler_reset}))
    else $error("Prescaler reset bits changed while held");

  a_normal_wrap: assert property (
    (i_clock_enable && tick && mode == WM_NORMAL && st.count == TMC_MAX_VALUE && !i_bus.wr)
      |=> (st.count == TMC_BOTTOM_VALUE) && st.flags[TMC_FLAG_OVF])
    else $error("Normal mode did not wrap and flag overflow at MAX");

  a_fast_load: assert property (
    (i_clock_enable && tick && mode == WM_FAST_CMPA && st.count == top && !i_bus.wr)
      |=> (st.cmp_a == $past(st.cmp_a_buf)) && (st.count == TMC_BOTTOM_VALUE))
    else $error("Fast PWM did not load compare at BOTTOM");

  a_ext_rise: assert property (
    (i_clock_enable && st.clock_select_field == CS_EXT_RISE && !pin_rise && !i_bus.wr)
      |=> $stable(st.count))
    else $error("Counter moved without a rising pin edge");

endmodule

// *** testbench/tmc_timer_core_test.sv ***
// Self-checking bench for the timer control core
module tmc_timer_core_test
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock;
  logic       resetn;
  logic       gie;
  logic       pin;
  logic       amode;
  logic       adone;
  logic       cen;
  logic [2:0] vack;
  tmc_iobus_t bus;
  logic [7:0] rdata;
  logic       wave_a;
  logic       wave_b;
  logic [2:0] irq;
  logic       psr_s;
  logic       psr_a;
  logic [7:0] v;
  int         mismatches;
  int         tests_run;
  int         p;

  // Mode table: start count, pin ticks, end count, overflow flag
  localparam logic [7:0] M_START [8] = '{8'hFE, 8'hFE, 8'h00, 8'hFE, 8'h05, 8'h00, 8'h05, 8'h00};
  localparam int         M_TICKS [8] = '{3, 3, 5, 3, 3, 7, 3, 5};
  localparam logic [7:0] M_END   [8] = '{8'h01, 8'hFD, 8'h01, 8'h01, 8'h05, 8'h01, 8'h05, 8'h01};
  localparam logic [7:0] M_OVF   [8] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01};

  tmc_timer_core u_tmc_timer_core (
    .i_clock                  (clock),
    .i_resetn                 (resetn),
    .i_clock_enable           (cen),
    .i_bus                    (bus),
    .i_global_irq_enable      (gie),
    .i_vector_ack             (vack),
    .i_external_count_pin     (pin),
    .i_async_mode             (amode),
    .i_async_reset_done       (adone),
    .o_rdata                  (rdata),
    .o_wave_out_a             (wave_a),
    .o_wave_out_b             (wave_b),
    .o_irq_request            (irq),
    .o_shared_prescaler_reset (psr_s),
    .o_async_prescaler_reset  (psr_a)
  );

  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
    d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp, "register read");
  endtask

  // One full pulse per tick on the count pin
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock);
      pin <= 1'b1;
      repeat (2) @(posedge clock);
      pin <= 1'b0;
      repeat (2) @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    gie = 1'b0;
    pin = 1'b0;
    amode = 1'b0;
    adone = 1'b0;
    cen = 1'b1;
    vack = 3'b000;
    bus = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;

    rchk(TMC_ADDR_SYNC, 8'h00);
    rchk(TMC_ADDR_CTRL_B, 8'h00);
    rchk(TMC_ADDR_COUNT, 8'h00);
    rchk(TMC_ADDR_MASK, 8'h00);
    rchk(8'h50, 8'h00);
    wr(TMC_ADDR_MASK, 8'hFF);
    rchk(TMC_ADDR_MASK, 8'h07);
    wr(TMC_ADDR_CTRL_B, 8'h3F);
    rchk(TMC_ADDR_CTRL_B, 8'h0F);
    wr(TMC_ADDR_CTRL_B, 8'h00);
    wr(TMC_ADDR_COUNT, 8'hA5);
    repeat (10) @(posedge clock);
    rchk(TMC_ADDR_COUNT, 8'hA5);
    $display("Test registers done");

    // Force strobes with toggle on both channels
    wr(TMC_ADDR_CTRL_A, 8'h50);
    wr(TMC_ADDR_CTRL_B, 8'h80);
    @(posedge clock);
    check({6'h00, wave_b, wave_a}, 8'h01, "force a");
    wr(TMC_ADDR_CTRL_B, 8'h40);
    @(posedge clock);
    check({6'h00, wave_b, wave_a}, 8'h03, "force b");
    rchk(TMC_ADDR_CTRL_B, 8'h00);
    rchk(TMC_ADDR_FLAGS, 8'h00);
    wr(TMC_ADDR_CTRL_A, 8'h52);
    wr(TMC_ADDR_COUNT, 8'h33);
    wr(TMC_ADDR_CTRL_B, 8'hC0);
    rchk(TMC_ADDR_COUNT, 8'h33);
    check({6'h00, wave_b, wave_a}, 8'h00, "force both");
    wr(TMC_ADDR_CTRL_A, 8'hF3);
    wr(TMC_ADDR_CTRL_B, 8'hC0);
    check({6'h00, wave_b, wave_a}, 8'h00, "force in pwm");
    $display("Test force compare done");

    // Waveform modes driven by rising pin edges, then counting on falling pin edges
    wr(TMC_ADDR_CTRL_A, 8'h00);
    wr(TMC_ADDR_CMP_A, 8'h03);
    for (int m = 0; m < 8; m++) begin
      wr(TMC_ADDR_CTRL_A, {6'h00, m[1:0]});
      wr(TMC_ADDR_CTRL_B, {4'h0, m[2], 3'b111});
      wr(TMC_ADDR_COUNT, M_START[m]);
      wr(TMC_ADDR_FLAGS, 8'h07);
      ticks(M_TICKS[m]);
      rchk(TMC_ADDR_COUNT, M_END[m]);
      rd(TMC_ADDR_FLAGS, v);
      check(v & 8'h01, M_OVF[m], "overflow flag");
    end
    wr(TMC_ADDR_CTRL_A, 8'h00);
    wr(TMC_ADDR_COUNT, 8'h00);
    wr(TMC_ADDR_CTRL_B, 8'h06);
    ticks(4);
    rchk(TMC_ADDR_COUNT, 8'h04);
    $display("Test modes done");

    // Compare flags, requests and clearing
    wr(TMC_ADDR_CTRL_B, 8'h07);
    wr(TMC_ADDR_CMP_A, 8'h05);
    wr(TMC_ADDR_CMP_B, 8'h06);
    wr(TMC_ADDR_COUNT, 8'h04);
    wr(TMC_ADDR_FLAGS, 8'h07);
    wr(TMC_ADDR_MASK, 8'h07);
    gie <= 1'b1;
    ticks(2);
    check({5'h00, irq}, 8'h02, "compare a request");
    ticks(1);
    check({5'h00, irq}, 8'h06, "compare b request");
    @(posedge clock);
    vack <= 3'b010;
    @(posedge clock);
    vack <= 3'b000;
    repeat (3) @(posedge clock);
    check({5'h00, irq}, 8'h04, "vector clear");
    rchk(TMC_ADDR_FLAGS, 8'h04);
    wr(TMC_ADDR_FLAGS, 8'h04);
    rchk(TMC_ADDR_FLAGS, 8'h00);
    gie <= 1'b0;
    wr(TMC_ADDR_COUNT, 8'hFE);
    ticks(2);
    check({5'h00, irq}, 8'h00, "global off");
    gie <= 1'b1;
    repeat (3) @(posedge clock);
    check({5'h00, irq}, 8'h01, "overflow request");
    wr(TMC_ADDR_MASK, 8'h00);
    repeat (3) @(posedge clock);
    check({5'h00, irq}, 8'h00, "masked");
    wr(TMC_ADDR_FLAGS, 8'h07);
    wr(TMC_ADDR_CTRL_A, 8'hC0);
    wr(TMC_ADDR_CMP_A, 8'h20);
    wr(TMC_ADDR_COUNT, 8'h20);
    ticks(1);
    rchk(TMC_ADDR_FLAGS, 8'h00);
    check({7'h00, wave_a}, 8'h00, "wave blocked");
    wr(TMC_ADDR_COUNT, 8'h1F);
    ticks(2);
    rchk(TMC_ADDR_FLAGS, 8'h02);
    check({7'h00, wave_a}, 8'h01, "wave set on match");
    $display("Test interrupts done");

    // Internal clock and prescaler taps
    for (int c = 1; c <= 5; c++) begin
      p = (c == 1) ? 1 : (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024;
      wr(TMC_ADDR_COUNT, 8'h00);
      wr(TMC_ADDR_CTRL_B, c[7:0]);
      repeat (10 * p) @(posedge clock);
      wr(TMC_ADDR_CTRL_B, 8'h00);
      rd(TMC_ADDR_COUNT, v);
      check({7'h00, v >= 8'h0A && v <= 8'h0C}, 8'h01, "prescaled count");
    end
    // Clock enable low freezes the running counter
    wr(TMC_ADDR_COUNT, 8'h40);
    wr(TMC_ADDR_CTRL_B, 8'h01);
    cen <= 1'b0;
    repeat (20) @(posedge clock);
    cen <= 1'b1;
    wr(TMC_ADDR_CTRL_B, 8'h00);
    rchk(TMC_ADDR_COUNT, 8'h42);
    $display("Test prescaler done");

    // Prescaler reset bits and sync hold
    wr(TMC_ADDR_SYNC, 8'h01);
    rchk(TMC_ADDR_SYNC, 8'h00);
    wr(TMC_ADDR_SYNC, 8'h81);
    @(posedge clock);
    check({7'h00, psr_s}, 8'h01, "shared reset held");
    wr(TMC_ADDR_COUNT, 8'h00);
    wr(TMC_ADDR_CTRL_B, 8'h02);
    repeat (100) @(posedge clock);
    rchk(TMC_ADDR_COUNT, 8'h00);
    wr(TMC_ADDR_CTRL_B, 8'h00);
    wr(TMC_ADDR_SYNC, 8'h83);
    rchk(TMC_ADDR_SYNC, 8'h83);
    wr(TMC_ADDR_SYNC, 8'h00);
    rchk(TMC_ADDR_SYNC, 8'h00);
    check({6'h00, psr_s, psr_a}, 8'h00, "both released");
    amode <= 1'b1;
    wr(TMC_ADDR_SYNC, 8'h02);
    repeat (5) @(posedge clock);
    check({7'h00, psr_a}, 8'h01, "async pending");
    adone <= 1'b1;
    repeat (3) @(posedge clock);
    check({7'h00, psr_a}, 8'h00, "async done");
    amode <= 1'b0;
    $display("Test prescaler reset done");
    end_sim();
  end

endmodule
